/* File: quad_timer_pkg.sv */
// Constants, mode codes and decode functions for the quad timer block.
// Assumes one 50 MHz timer clock and a host on an asynchronous strobe bus.
//
// Function
// - Each timer has an 8-bit main counter, decremented once per count pulse.
// - Data register read returns counter captured at last strobe rising edge.
// - Data write to a stopped timer loads holding register and counter together.
// - Data write to a running timer updates holding register; counter reloads after 01.
// - Bit 4 of A/B control forces output low during the write only.
// - A/B mode field: stop, delay with seven prescales, event count, pulse width.
// - C/D control holds two 3-bit fields: stop or delay with seven prescales.
// - Stopped timer holds counter, inhibits counting, drops prescaler residue.
// - Unused control bits read back as zero.
// - Delay mode: prescaler pulses, counting through 01 reloads and times out.
// - Counter loaded 00 times out every 256 pulses; loaded 01 every pulse.
// - Pulse width mode gates prescaler and counter by the active aux level.
// - Event count mode bypasses prescaler; each active aux edge counts once.
package quad_timer_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned ADDR_W = 6;
    localparam logic [5:0] OFS_A_CTRL = 6'h19;
    localparam logic [5:0] OFS_B_CTRL = 6'h1A;
    localparam logic [5:0] OFS_CD_CTRL = 6'h1D;
    localparam logic [5:0] OFS_A_DATA = 6'h1F;
    localparam logic [5:0] OFS_B_DATA = 6'h21;
    localparam logic [5:0] OFS_C_DATA = 6'h23;
    localparam logic [5:0] OFS_D_DATA = 6'h25;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int unsigned FORCE_LOW_BIT = 4;
    localparam int unsigned MODE_C_LSB = 4;
    localparam int unsigned MODE_D_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] DATA_ZERO = 8'h00;
    localparam logic [3:0] CODE_STOP = 4'h0;
    localparam logic [3:0] CODE_EVENT = 4'h8;
    // Sync chain order: aux_b, aux_a, rw, strobe_n, cs_n
    localparam logic [4:0] SYNC_RESET = 5'h07;

    // ************************************************************
    // Prescale divisors
    // ************************************************************
    localparam logic [7:0] PSC_4 = 8'h04;
    localparam logic [7:0] PSC_10 = 8'h0A;
    localparam logic [7:0] PSC_16 = 8'h10;
    localparam logic [7:0] PSC_50 = 8'h32;
    localparam logic [7:0] PSC_64 = 8'h40;
    localparam logic [7:0] PSC_100 = 8'h64;
    localparam logic [7:0] PSC_200 = 8'hC8;

    typedef enum logic [1:0] {MODE_STOP, MODE_DELAY, MODE_EVENT, MODE_PULSE} tmode_e;

    // Mode from a 4-bit code; C/D codes are zero-extended
    function automatic tmode_e mode_of(input logic [3:0] code);
        tmode_e m;
        m = MODE_DELAY;
        if (code == CODE_STOP) begin
            m = MODE_STOP;
        end else if (code == CODE_EVENT) begin
            m = MODE_EVENT;
        end else if (code[3]) begin
            m = MODE_PULSE;
        end
        return m;
    endfunction

    // Prescale divisor from the low three code bits
    function automatic logic [7:0] div_of(input logic [2:0] sel);
        logic [7:0] d;
        d = PSC_4;
        case (sel)
            3'h1: d = PSC_4;
            3'h2: d = PSC_10;
            3'h3: d = PSC_16;
            3'h4: d = PSC_50;
            3'h5: d = PSC_64;
            3'h6: d = PSC_100;
            3'h7: d = PSC_200;
            default: d = PSC_4;
        endcase
        return d;
    endfunction

endpackage

/* File: quad_timer_register_control.sv */
// Four 8-bit down-counting timers with their data and control registers.
// Assumes the host strobe bus pins are asynchronous to clk and that
// addr and data_in are stable while the strobe is low.
`timescale 1ns/1ns
`default_nettype none
module quad_timer_register_control
    import quad_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host bus
    input wire logic cs_n,
    input wire logic bus_data_strobe_n,
    input wire logic rw,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic dtack_n,
    // Auxiliary inputs, polarity bit 1 for A, bit 0 for B
    input wire logic timer_a_aux_input,
    input wire logic timer_b_aux_input,
    input wire logic [1:0] edge_polarity_bits,
    // Timer outputs
    output logic timer_a_output,
    output logic timer_b_output,
    output logic [3:0] timeout_pulse
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [4:0] sync3_r;
    logic [4:0] lvl_r;
    logic [4:0] lvl_d_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= SYNC_RESET;
            sync2_r <= SYNC_RESET;
            sync3_r <= SYNC_RESET;
        end else begin
            sync1_r <= {timer_b_aux_input, timer_a_aux_input, rw, bus_data_strobe_n, cs_n};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_r <= SYNC_RESET;
            lvl_d_r <= SYNC_RESET;
        end else begin
            for (int k = 0; k < 5; k++) begin
                if (sync2_r[k] == sync3_r[k]) begin
                    lvl_r[k] <= sync3_r[k];
                end
            end
            lvl_d_r <= lvl_r;
        end
    end

    logic sel_act;
    logic ds_fall;
    logic ds_rise;
    logic rd_act;
    logic wr_stb;
    logic [1:0] aux_lvl;
    logic [1:0] aux_prev;

    assign sel_act = !lvl_r[0] && !lvl_r[1];
    assign ds_fall = !lvl_r[1] && lvl_d_r[1];
    assign ds_rise = lvl_r[1] && !lvl_d_r[1];
    assign rd_act = sel_act && lvl_r[2];
    assign wr_stb = ds_fall && !lvl_r[0] && !lvl_r[2];
    assign aux_lvl = {lvl_r[3], lvl_r[4]};
    assign aux_prev = {lvl_d_r[3], lvl_d_r[4]};

    // ************************************************************
    // Control registers
    // ************************************************************
    logic [3:0] timer_a_mode_field_r;
    logic [3:0] timer_b_mode_field_r;
    logic [2:0] timer_c_mode_field_r;
    logic [2:0] timer_d_mode_field_r;
    logic force_a_r;
    logic force_b_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_a_mode_field_r <= CTRL_RESET[3:0];
            timer_b_mode_field_r <= CTRL_RESET[3:0];
            timer_c_mode_field_r <= CTRL_RESET[2:0];
            timer_d_mode_field_r <= CTRL_RESET[2:0];
        end else if (wr_stb) begin
            case (addr)
                OFS_A_CTRL: timer_a_mode_field_r <= data_in[3:0];
                OFS_B_CTRL: timer_b_mode_field_r <= data_in[3:0];
                OFS_CD_CTRL: begin
                    timer_c_mode_field_r <= data_in[MODE_C_LSB +: 3];
                    timer_d_mode_field_r <= data_in[MODE_D_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // Force-low lasts from strobe start to strobe end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            force_a_r <= 1'b0;
            force_b_r <= 1'b0;
        end else if (ds_rise) begin
            force_a_r <= 1'b0;
            force_b_r <= 1'b0;
        end else if (wr_stb) begin
            if (addr == OFS_A_CTRL) begin
                force_a_r <= data_in[FORCE_LOW_BIT];
            end
            if (addr == OFS_B_CTRL) begin
                force_b_r <= data_in[FORCE_LOW_BIT];
            end
        end
    end

    // ************************************************************
    // Per-timer decode
    // ************************************************************
    logic [3:0] code [4];
    tmode_e mode [4];
    logic [7:0] div [4];
    logic [3:0] gate;
    logic [3:0] evt;
    logic [3:0] wr_data;
    logic [7:0] cnt_r [4];
    logic [7:0] reload_r [4];
    logic [7:0] pre_r [4];
    logic [7:0] snap_r [4];
    logic [3:0] cp;
    logic [3:0] pre_end;

    always_comb begin
        code[0] = timer_a_mode_field_r;
        code[1] = timer_b_mode_field_r;
        code[2] = {1'b0, timer_c_mode_field_r};
        code[3] = {1'b0, timer_d_mode_field_r};
        wr_data[0] = wr_stb && (addr == OFS_A_DATA);
        wr_data[1] = wr_stb && (addr == OFS_B_DATA);
        wr_data[2] = wr_stb && (addr == OFS_C_DATA);
        wr_data[3] = wr_stb && (addr == OFS_D_DATA);
        gate = 4'hF;
        evt = 4'h0;
        for (int i = 0; i < 2; i++) begin
            // Active level and active edge follow the polarity bit
            gate[i] = (aux_lvl[1-i] == edge_polarity_bits[1-i]);
            evt[i] = (aux_lvl[1-i] != aux_prev[1-i]) && gate[i];
        end
        for (int i = 0; i < 4; i++) begin
            mode[i] = mode_of(code[i]);
            div[i] = div_of(code[i][2:0]);
            pre_end[i] = (pre_r[i] >= div[i] - 8'h01);
            case (mode[i])
                MODE_DELAY: cp[i] = pre_end[i];
                MODE_PULSE: cp[i] = pre_end[i] && gate[i];
                MODE_EVENT: cp[i] = evt[i];
                default: cp[i] = 1'b0;
            endcase
        end
    end

    // ************************************************************
    // Prescalers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                pre_r[i] <= CNT_RESET;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                case (mode[i])
                    MODE_DELAY: pre_r[i] <= pre_end[i] ? CNT_RESET : 8'(pre_r[i] + 8'h01);
                    MODE_PULSE: begin
                        if (gate[i]) begin
                            pre_r[i] <= pre_end[i] ? CNT_RESET : 8'(pre_r[i] + 8'h01);
                        end
                    end
                    default: pre_r[i] <= CNT_RESET;
                endcase
            end
        end
    end

    // ************************************************************
    // Main counters and holding registers
    // ************************************************************
    logic [3:0] timeout_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                cnt_r[i] <= CNT_RESET;
                reload_r[i] <= CNT_RESET;
            end
            timeout_r <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_data[i]) begin
                    reload_r[i] <= data_in;
                end
                if (wr_data[i] && mode[i] == MODE_STOP) begin
                    cnt_r[i] <= data_in;
                end else if (cp[i]) begin
                    if (cnt_r[i] == CNT_ONE) begin
                        // Write in this cycle wins; value is undefined for software
                        cnt_r[i] <= wr_data[i] ? data_in : reload_r[i];
                    end else begin
                        // 00 wraps to FF, giving 256 pulses per timeout
                        cnt_r[i] <= 8'(cnt_r[i] - 8'h01);
                    end
                end
                timeout_r[i] <= cp[i] && (cnt_r[i] == CNT_ONE);
            end
        end
    end

    // ************************************************************
    // Timer outputs
    // ************************************************************
    logic out_a_r;
    logic out_b_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
        end else begin
            if (force_a_r) begin
                out_a_r <= 1'b0;
            end else if (timeout_r[0]) begin
                out_a_r <= !out_a_r;
            end
            if (force_b_r) begin
                out_b_r <= 1'b0;
            end else if (timeout_r[1]) begin
                out_b_r <= !out_b_r;
            end
        end
    end

    assign timer_a_output = out_a_r;
    assign timer_b_output = out_b_r;
    assign timeout_pulse = timeout_r;

    // ************************************************************
    // Read path
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                snap_r[i] <= CNT_RESET;
            end
        end else if (ds_rise) begin
            for (int i = 0; i < 4; i++) begin
                snap_r[i] <= cnt_r[i];
            end
        end
    end

    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = DATA_ZERO;
        case (addr)
            OFS_A_CTRL: rd_mux = {3'h0, force_a_r, timer_a_mode_field_r};
            OFS_B_CTRL: rd_mux = {3'h0, force_b_r, timer_b_mode_field_r};
            OFS_CD_CTRL: rd_mux = {1'b0, timer_c_mode_field_r, 1'b0, timer_d_mode_field_r};
            OFS_A_DATA: rd_mux = snap_r[0];
            OFS_B_DATA: rd_mux = snap_r[1];
            OFS_C_DATA: rd_mux = snap_r[2];
            OFS_D_DATA: rd_mux = snap_r[3];
            default: rd_mux = DATA_ZERO;
        endcase
    end

    logic [7:0] data_out_r;
    logic data_oe_n_r;
    logic dtack_n_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out_r <= DATA_ZERO;
            data_oe_n_r <= 1'b1;
            dtack_n_r <= 1'b1;
        end else begin
            data_out_r <= rd_act ? rd_mux : DATA_ZERO;
            data_oe_n_r <= !rd_act;
            dtack_n_r <= !sel_act;
        end
    end

    assign data_out = data_out_r;
    assign data_oe_n = data_oe_n_r;
    assign dtack_n = dtack_n_r;

endmodule
`default_nettype wire

/* File: quad_timer_checker.sv */
// Port-level checks for the quad timer block, bound to its top module.
// Assumes one clk domain and the active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module quad_timer_checker
    import quad_timer_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host bus
    input wire logic cs_n,
    input wire logic bus_data_strobe_n,
    input wire logic rw,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    input wire logic dtack_n,
    // Timer pins
    input wire logic timer_a_aux_input,
    input wire logic timer_b_aux_input,
    input wire logic [1:0] edge_polarity_bits,
    input wire logic timer_a_output,
    input wire logic timer_b_output,
    input wire logic [3:0] timeout_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****
    // Sequences
    // ****
    sequence s_quiet;
        (timeout_pulse == 4'h0 && !timer_a_output && !timer_b_output) [*4];
    endsequence
    // Start of a timer A control write that sets the force bit
    sequence s_force_a;
        $fell(bus_data_strobe_n) && !cs_n && !rw && addr == OFS_A_CTRL
            && data_in[FORCE_LOW_BIT];
    endsequence
    // Sync, strobe filter, write edge and output flop: six clocks
    sequence s_out_a_low;
        ##6 !timer_a_output;
    endsequence
    // ****
    // Assertions
    // ****
    a_pulse_single: assert property (
        (timeout_pulse & $past(timeout_pulse)) == 4'h0) else $error("timeout pulse too long");
    a_toggle_a: assert property (
        timeout_pulse[0] && dtack_n && cs_n |=> timer_a_output != $past(timer_a_output))
        else $error("timer a output missed a toggle");
    a_toggle_b: assert property (
        timeout_pulse[1] && dtack_n && cs_n |=> timer_b_output != $past(timer_b_output))
        else $error("timer b output missed a toggle");
    a_force_low: assert property (
        s_force_a |-> s_out_a_low) else $error("timer a output not forced low");
    a_oe_ack: assert property (
        !data_oe_n |-> !dtack_n) else $error("data driven without acknowledge");
    a_idle_data: assert property (
        data_oe_n |-> data_out == 8'h00) else $error("read data not zero when idle");
    a_ack_release: assert property (
        bus_data_strobe_n [*8] |-> dtack_n) else $error("acknowledge not released");
    a_ack_cause: assert property (
        $fell(dtack_n) |-> $past(!cs_n && !bus_data_strobe_n, 3))
        else $error("acknowledge without access");
    a_reset_idle: assert property (
        $rose(rst_n) |-> s_quiet) else $error("timer active after reset");
endmodule
bind quad_timer_register_control quad_timer_checker checker_i (
    .clk, .rst_n, .cs_n, .bus_data_strobe_n, .rw, .addr, .data_in, .data_out,
    .data_oe_n, .dtack_n, .timer_a_aux_input, .timer_b_aux_input,
    .edge_polarity_bits, .timer_a_output, .timer_b_output, .timeout_pulse);
`default_nettype wire

/* File: host_bus_model.sv */
// Host model: strobe-bus reads and writes toward the quad timer block.
// Assumes callers enter its task just after a falling clk edge.
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
    import quad_timer_pkg::*;
(
    // Clock
    input wire logic clk,
    // Bus
    output logic cs_n,
    output logic bus_data_strobe_n,
    output logic rw,
    output logic [ADDR_W-1:0] addr,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic dtack_n
);
    initial begin
        cs_n = 1'b1;
        bus_data_strobe_n = 1'b1;
        rw = 1'b1;
        addr = 6'h00;
        data_in = 8'h00;
    end
    // ****
    // Access
    // ****
    task automatic access(input logic rd, input logic [5:0] a, input logic [7:0] wd,
                          output logic [7:0] rdat);
        int n;
        n = 0;
        rdat = 8'hXX;
        rw = rd;
        addr = a;
        data_in = wd;
        cs_n = 1'b0;
        bus_data_strobe_n = 1'b0;
        while (dtack_n !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n < 40) begin
            rdat = data_out;
        end
        cs_n = 1'b1;
        bus_data_strobe_n = 1'b1;
        // Released lines must not keep the last value
        addr = ~a;
        data_in = ~wd;
        n = 0;
        while (dtack_n !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the quad timer block and its host bus.
// Assumes the package, host model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import quad_timer_pkg::*;
;
    typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] e;} row_s;
    typedef struct {int b; logic [5:0] da; logic [5:0] ca; logic [7:0] dv;
        logic [7:0] cv; logic [15:0] p;} per_s;
    logic clk, rst_n, cs_n, bus_data_strobe_n, rw, data_oe_n, dtack_n;
    logic [5:0] addr;
    logic [7:0] data_in, data_out, r;
    logic timer_a_aux_input, timer_b_aux_input, timer_a_output, timer_b_output, v;
    logic [1:0] edge_polarity_bits;
    logic [3:0] timeout_pulse;
    logic [15:0] c, n0;
    logic [15:0] seen[4] = '{default: 16'h0000};
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    logic [5:0] ctl[3] = '{OFS_A_CTRL, OFS_B_CTRL, OFS_CD_CTRL};
    row_s rows[8] = '{'{OFS_A_DATA, 8'h5A, 8'h5A}, '{OFS_B_DATA, 8'hA5, 8'hA5},
        '{OFS_C_DATA, 8'h00, 8'h00}, '{OFS_D_DATA, 8'hFF, 8'hFF}, '{OFS_A_CTRL, 8'hFF, 8'h0F},
        '{OFS_B_CTRL, 8'hE8, 8'h08}, '{OFS_CD_CTRL, 8'hFF, 8'h77}, '{6'h1B, 8'hFF, 8'h00}};
    per_s pers[8] = '{'{0, OFS_A_DATA, OFS_A_CTRL, 8'h01, 8'h01, 16'h0004},
        '{1, OFS_B_DATA, OFS_B_CTRL, 8'h03, 8'h02, 16'h001E},
        '{2, OFS_C_DATA, OFS_CD_CTRL, 8'h02, 8'h30, 16'h0020},
        '{3, OFS_D_DATA, OFS_CD_CTRL, 8'h00, 8'h31, 16'h0400},
        '{0, OFS_A_DATA, OFS_A_CTRL, 8'h01, 8'h04, 16'h0032},
        '{0, OFS_A_DATA, OFS_A_CTRL, 8'h01, 8'h05, 16'h0040},
        '{0, OFS_A_DATA, OFS_A_CTRL, 8'h01, 8'h06, 16'h0064},
        '{1, OFS_B_DATA, OFS_B_CTRL, 8'h01, 8'h07, 16'h00C8}};
    quad_timer_register_control dut (.clk, .rst_n, .cs_n, .bus_data_strobe_n, .rw, .addr,
        .data_in, .data_out, .data_oe_n, .dtack_n, .timer_a_aux_input, .timer_b_aux_input,
        .edge_polarity_bits, .timer_a_output, .timer_b_output, .timeout_pulse);
    host_bus_model host (.clk, .cs_n, .bus_data_strobe_n, .rw, .addr, .data_in, .data_out,
        .dtack_n);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        for (int i = 0; i < 4; i++) begin
            if (timeout_pulse[i] === 1'b1) seen[i] <= seen[i] + 16'h0001;
        end
        if (cycles == 30000) begin
            failures++;
            report_and_stop();
        end
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.access(1'b0, a, d, x);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        host.access(1'b1, a, 8'h00, d);
    endtask
    task automatic count_tp(input int b, input int n, output logic [15:0] k);
        logic [15:0] s;
        s = seen[b];
        repeat (n) @(negedge clk);
        k = seen[b] - s;
    endtask
    task automatic interval(input int b, output logic [15:0] k);
        int n;
        n = 0;
        while (timeout_pulse[b] !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        k = 16'h0001;
        while (timeout_pulse[b] !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic reset_check();
        logic [7:0] x;
        chk("idle pins", {data_out, timeout_pulse, timer_a_output, timer_b_output, dtack_n,
            data_oe_n}, 16'h0003);
        foreach (ctl[i]) begin
            rd(ctl[i], x);
            chk("control reset", {8'h00, x}, 16'h0000);
        end
        $display("test reset done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        rst_n = 1'b0;
        timer_a_aux_input = 1'b0;
        timer_b_aux_input = 1'b0;
        edge_polarity_bits = 2'b00;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        reset_check();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, r);
            chk("readback", {8'h00, r}, {8'h00, rows[i].e});
        end
        foreach (pers[i]) begin
            wr(pers[i].ca, 8'h00);
            wr(pers[i].da, pers[i].dv);
            wr(pers[i].ca, pers[i].cv);
            interval(pers[i].b, c);
            chk("period", c, pers[i].p);
        end
        $display("test table done");
        wr(OFS_A_CTRL, 8'h00);
        wr(OFS_A_DATA, 8'h00);
        wr(OFS_A_CTRL, 8'h01);
        interval(0, c);
        wr(OFS_A_DATA, 8'h01);
        count_tp(0, 200, c);
        chk("no early reload", c, 16'h0000);
        interval(0, c);
        chk("reload period", c, 16'h0004);
        wr(OFS_A_CTRL, 8'h11);
        rd(OFS_A_CTRL, r);
        chk("force bit", {8'h00, r}, 16'h0001);
        interval(0, c);
        v = timer_a_output;
        @(negedge clk);
        chk("toggle after force", {15'h0000, timer_a_output}, {15'h0000, ~v});
        $display("test reload and force done");
        wr(OFS_A_CTRL, 8'h00);
        wr(OFS_A_DATA, 8'h80);
        wr(OFS_A_CTRL, 8'h07);
        repeat (100) @(negedge clk);
        wr(OFS_A_CTRL, 8'h00);
        wr(OFS_A_CTRL, 8'h07);
        repeat (150) @(negedge clk);
        wr(OFS_A_CTRL, 8'h00);
        rd(OFS_A_DATA, r);
        chk("held count", {8'h00, r}, 16'h0080);
        $display("test stop done");
        edge_polarity_bits = 2'b10;
        wr(OFS_A_DATA, 8'h03);
        wr(OFS_A_CTRL, 8'h08);
        n0 = seen[0];
        repeat (3) begin
            timer_a_aux_input = 1'b1;
            repeat (8) @(negedge clk);
            timer_a_aux_input = 1'b0;
            repeat (8) @(negedge clk);
        end
        chk("event timeouts", seen[0] - n0, 16'h0001);
        edge_polarity_bits = 2'b11;
        wr(OFS_B_CTRL, 8'h00);
        wr(OFS_B_DATA, 8'h02);
        wr(OFS_B_CTRL, 8'h09);
        count_tp(1, 64, c);
        chk("gated off", c, 16'h0000);
        timer_b_aux_input = 1'b1;
        repeat (8) @(negedge clk);
        count_tp(1, 64, c);
        chk("gated on", c, 16'h0008);
        $display("test aux modes done");
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        reset_check();
        report_and_stop();
    end
endmodule
`default_nettype wire
